// *** mwc_map.svh ***
// constants for the write-cycle controller: widths, timing figures and cycle counts
`ifndef MWC_MAP_SVH
`define MWC_MAP_SVH

// pin and timer widths
`define MWC_ADDR_W      19
`define MWC_DATA_W      8
`define MWC_TMR_W       8

// system clock rate in MHz (40 ns period)
`define MWC_CLK_MHZ     25

// timing figures in ns, as printed
`define MWC_T_CYCLE_NS     35
`define MWC_T_PULSE_NS     15
`define MWC_T_AV_GHI_NS    18
`define MWC_T_AV_GLO_NS    20
`define MWC_T_DSETUP_NS    10
`define MWC_T_DHOLD_NS     0
`define MWC_T_RELEASE_NS   12
`define MWC_T_HIGH_NS      2
`define MWC_T_RECOVER_NS   12
`define MWC_T_SETUP_NS     0

// least time in ns to whole clock cycles, rounded up, never below one
`define MWC_NS2CYC(ns) ((((ns) * `MWC_CLK_MHZ) + 999) / 1000 > 0 ? \
                        (((ns) * `MWC_CLK_MHZ) + 999) / 1000 : 1)

`define MWC_CYC_CYCLE      `MWC_NS2CYC(`MWC_T_CYCLE_NS)
`define MWC_CYC_PULSE      `MWC_NS2CYC(`MWC_T_PULSE_NS)
`define MWC_CYC_AV_GHI     `MWC_NS2CYC(`MWC_T_AV_GHI_NS)
`define MWC_CYC_AV_GLO     `MWC_NS2CYC(`MWC_T_AV_GLO_NS)
`define MWC_CYC_DSETUP     `MWC_NS2CYC(`MWC_T_DSETUP_NS)
`define MWC_CYC_RELEASE    `MWC_NS2CYC(`MWC_T_RELEASE_NS)
`define MWC_CYC_HIGH       `MWC_NS2CYC(`MWC_T_HIGH_NS)
`define MWC_CYC_RECOVER    `MWC_NS2CYC(`MWC_T_RECOVER_NS)
`define MWC_CYC_SETUP      `MWC_NS2CYC(`MWC_T_SETUP_NS)

`endif

// *** mwc_pkg.sv ***
// types shared by the write-cycle controller files
`include "mwc_map.svh"

package mwc_pkg;

  // which strobe ends the write
  typedef enum logic {
    MWC_WE_CTRL = 1'b0,
    MWC_CE_CTRL = 1'b1
  } mwc_mode_t;

  typedef enum logic [1:0] {
    MWC_IDLE    = 2'b00,
    MWC_SETUP   = 2'b01,
    MWC_STROBE  = 2'b10,
    MWC_RECOVER = 2'b11
  } mwc_state_t;

  // one write request from the user side
  typedef struct packed {
    mwc_mode_t                  mode;
    logic                       oe_low;
    logic [`MWC_ADDR_W-1:0]     addr;
    logic [`MWC_DATA_W-1:0]     data;
  } mwc_req_t;

endpackage : mwc_pkg

// *** mwc_timer.sv ***
// loadable down counter that flags when it reaches zero
module mwc_timer #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // load wins over counting; saturates at zero
  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_count;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_done = (count == '0);

endmodule : mwc_timer

// *** mwc_ctrl.sv ***
// host-side write-cycle controller for an asynchronous byte-wide non-volatile ram
//
// Summary of operation
// - a raised strobe stays high at least 2 ns before falling again
// - chip select falling edges are spaced at least 35 ns apart
// - address stays stable from valid until the cycle fully ends
// - write-strobe-ended writes hold write strobe low at least 15 ns
// - address valid 18 ns before write end, 20 ns with output drive low
// - data valid 10 ns before write end, held 0 ns after it
// - chip-select-ended writes hold select low at least 15 ns
`include "mwc_map.svh"

module mwc_ctrl (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // user request side
  input  wire logic                    i_req_valid,
  input  wire mwc_pkg::mwc_req_t       i_req,
  output logic                         o_req_ready,
  output logic                         o_done,
  // memory pins
  output logic [`MWC_ADDR_W-1:0]       o_mem_addr,
  output logic                         o_mem_ce_n,
  output logic                         o_mem_we_n,
  output logic                         o_mem_oe_n,
  output logic [`MWC_DATA_W-1:0]       o_mem_dq,
  output logic                         o_mem_dq_oe,
  input  wire logic [`MWC_DATA_W-1:0]  i_mem_dq
);

  localparam int TW = `MWC_TMR_W;

  // larger of two cycle counts, minus one for timer load
  function automatic logic [TW-1:0] mwc_load(input int a, input int b);
    int m;
    m = (a > b) ? a : b;
    mwc_load = TW'(m - 1);
  endfunction : mwc_load

  // saturating increment for the age counters
  function automatic logic [TW-1:0] mwc_inc(input logic [TW-1:0] v);
    mwc_inc = (v == {TW{1'b1}}) ? v : v + TW'(1);
  endfunction : mwc_inc

  mwc_pkg::mwc_state_t            state;
  mwc_pkg::mwc_state_t            next_state;
  mwc_pkg::mwc_mode_t             mode;
  mwc_pkg::mwc_mode_t             next_mode;
  logic                           oe_low;
  logic                           next_oe_low;
  logic [`MWC_ADDR_W-1:0]         next_mem_addr;
  logic [`MWC_DATA_W-1:0]         next_mem_dq;
  logic                           next_mem_ce_n;
  logic                           next_mem_we_n;
  logic                           next_mem_oe_n;
  logic                           next_mem_dq_oe;
  logic                           next_done;
  logic [TW-1:0]                  wl_age;
  logic [TW-1:0]                  next_wl_age;
  logic [TW-1:0]                  dq_age;
  logic [TW-1:0]                  next_dq_age;
  logic                           ph_load;
  logic [TW-1:0]                  ph_count;
  logic                           ph_done;
  logic                           cyc_load;
  logic                           cyc_done;
  logic                           data_ready;
  logic                           release_ok;

  // phase timer paces setup, strobe and recovery
  mwc_timer #(
    .W (TW)
  ) u_phase (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_load   (ph_load),
    .i_count  (ph_count),
    .o_done   (ph_done)
  );

  // cycle timer starts on every chip select fall
  mwc_timer #(
    .W (TW)
  ) u_cycle (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_load   (cyc_load),
    .i_count  (mwc_load(`MWC_CYC_CYCLE, 1)),
    .o_done   (cyc_done)
  );

  assign cyc_load = o_mem_ce_n && !next_mem_ce_n;

  // new request only once the previous select fall is a full cycle old
  assign o_req_ready = (state == mwc_pkg::MWC_IDLE) && cyc_done;

  // memory may still drive until its release time after write strobe falls
  assign release_ok = !oe_low || (!o_mem_we_n && wl_age >= TW'(`MWC_CYC_RELEASE - 1));
  // data has stood long enough before the terminating edge
  assign data_ready = o_mem_dq_oe && (dq_age >= TW'(`MWC_CYC_DSETUP - 1));

  // sequencer: pins and phase changes
  always_comb begin
    next_state     = state;
    next_mode      = mode;
    next_oe_low    = oe_low;
    next_mem_addr  = o_mem_addr;
    next_mem_dq    = o_mem_dq;
    next_mem_ce_n  = o_mem_ce_n;
    next_mem_we_n  = o_mem_we_n;
    next_mem_oe_n  = o_mem_oe_n;
    next_mem_dq_oe = o_mem_dq_oe;
    next_done      = 1'b0;
    ph_load        = 1'b0;
    ph_count       = '0;
    case (state)
      mwc_pkg::MWC_IDLE: begin
        if (i_req_valid && o_req_ready) begin
          next_mode     = i_req.mode;
          next_oe_low   = i_req.oe_low;
          next_mem_addr = i_req.addr;
          next_mem_dq   = i_req.data;
          // the non-terminating strobe falls first
          next_mem_ce_n = (i_req.mode == mwc_pkg::MWC_CE_CTRL);
          next_mem_we_n = (i_req.mode == mwc_pkg::MWC_WE_CTRL);
          // output drive low only with write strobe, so no read contention
          next_mem_oe_n = !(i_req.oe_low && !next_mem_we_n);
          next_mem_dq_oe = !i_req.oe_low;
          next_state    = mwc_pkg::MWC_SETUP;
          ph_load       = 1'b1;
          ph_count      = mwc_load(`MWC_CYC_SETUP, 1);
        end
      end
      mwc_pkg::MWC_SETUP: begin
        next_mem_dq_oe = o_mem_dq_oe || release_ok;
        if (ph_done) begin
          // both strobes low: the write interval opens
          next_mem_ce_n = 1'b0;
          next_mem_we_n = 1'b0;
          next_mem_oe_n = !oe_low;
          next_state    = mwc_pkg::MWC_STROBE;
          ph_load       = 1'b1;
          // pulse covers width and address-to-end; address went out a cycle before
          ph_count      = mwc_load(`MWC_CYC_PULSE,
                                   (oe_low ? `MWC_CYC_AV_GLO : `MWC_CYC_AV_GHI) - 1);
        end
      end
      mwc_pkg::MWC_STROBE: begin
        next_mem_dq_oe = o_mem_dq_oe || release_ok;
        if (ph_done && data_ready) begin
          // both strobes rise together; data released on the same edge (zero hold)
          next_mem_ce_n  = 1'b1;
          next_mem_we_n  = 1'b1;
          next_mem_oe_n  = 1'b1;
          next_mem_dq_oe = 1'b0;
          next_state     = mwc_pkg::MWC_RECOVER;
          ph_load        = 1'b1;
          ph_count       = mwc_load(`MWC_CYC_RECOVER, `MWC_CYC_HIGH);
        end
      end
      mwc_pkg::MWC_RECOVER: begin
        // address kept still until recovery has run out
        if (ph_done) begin
          next_done  = 1'b1;
          next_state = mwc_pkg::MWC_IDLE;
        end
      end
      default: begin
        next_state     = mwc_pkg::MWC_IDLE;
        next_mem_ce_n  = 1'b1;
        next_mem_we_n  = 1'b1;
        next_mem_oe_n  = 1'b1;
        next_mem_dq_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state       <= mwc_pkg::MWC_IDLE;
      mode        <= mwc_pkg::MWC_WE_CTRL;
      oe_low      <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_dq    <= '0;
      o_mem_ce_n  <= 1'b1;
      o_mem_we_n  <= 1'b1;
      o_mem_oe_n  <= 1'b1;
      o_mem_dq_oe <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      state       <= next_state;
      mode        <= next_mode;
      oe_low      <= next_oe_low;
      o_mem_addr  <= next_mem_addr;
      o_mem_dq    <= next_mem_dq;
      o_mem_ce_n  <= next_mem_ce_n;
      o_mem_we_n  <= next_mem_we_n;
      o_mem_oe_n  <= next_mem_oe_n;
      o_mem_dq_oe <= next_mem_dq_oe;
      o_done      <= next_done;
    end
  end

  // age counters: cycles since write strobe fell and since data went out
  always_comb begin
    next_wl_age = o_mem_we_n ? '0 : mwc_inc(wl_age);
    next_dq_age = o_mem_dq_oe ? mwc_inc(dq_age) : '0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wl_age <= '0;
      dq_age <= '0;
    end else begin
      wl_age <= next_wl_age;
      dq_age <= next_dq_age;
    end
  end

  // read-back pins are not used by a write-only controller
  logic unused_dq;
  assign unused_dq = ^{i_mem_dq, mode};

endmodule : mwc_ctrl

// *** mwc_ctrl_monitor.sv ***
// pin and handshake assertions for the write-cycle controller
`include "mwc_map.svh"
module mwc_ctrl_monitor (
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_req_valid,
  input  wire mwc_pkg::mwc_req_t      i_req,
  input  wire logic                   o_req_ready,
  input  wire logic                   o_done,
  input  wire logic [`MWC_ADDR_W-1:0] o_mem_addr,
  input  wire logic                   o_mem_ce_n,
  input  wire logic                   o_mem_we_n,
  input  wire logic                   o_mem_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic ov;
  logic take;
  // write window is the overlap of both strobes
  assign ov   = !o_mem_ce_n && !o_mem_we_n;
  assign take = i_req_valid && o_req_ready;
  a_addr_from_req: assert property (take |=> o_mem_addr == $past(i_req.addr))
    else $error("address differs from request");
  a_addr_before_end: assert property ($fell(ov) |-> $past(o_mem_addr, 2) == o_mem_addr)
    else $error("address moved before write end");
  a_addr_recover: assert property ($fell(ov) |=> $stable(o_mem_addr))
    else $error("address moved in recovery");
  a_data_before_end: assert property ($fell(ov) |-> $past(o_mem_dq_oe))
    else $error("data not driven before write end");
  a_strobe_high: assert property ($rose(o_mem_we_n) |=> o_mem_we_n)
    else $error("write strobe high too briefly");
  a_select_spacing: assert property ($fell(o_mem_ce_n) |-> !o_req_ready)
    else $error("ready right after select fall");
  a_pulse_extend: assert property ($rose(ov) && !o_mem_dq_oe |=> ov)
    else $error("strobe not stretched for late data");
  a_end_together: assert property ($rose(o_mem_ce_n) |-> o_mem_we_n)
    else $error("select rose before write strobe");
  a_done_latency: assert property (take && !i_req.oe_low |-> ##4 o_done)
    else $error("done late");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
endmodule : mwc_ctrl_monitor

bind mwc_ctrl mwc_ctrl_monitor mwc_ctrl_monitor_inst (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
  .o_mem_addr(o_mem_addr), .o_mem_ce_n(o_mem_ce_n), .o_mem_we_n(o_mem_we_n),
  .o_mem_dq_oe(o_mem_dq_oe));

// *** mwc_mem_model.sv ***
// behavioural byte-wide memory on the far side of the pins
`include "mwc_map.svh"
module mwc_mem_model (
  input  wire logic                   i_clk,
  input  wire logic [`MWC_ADDR_W-1:0] i_addr,
  input  wire logic                   i_ce_n,
  input  wire logic                   i_we_n,
  input  wire logic                   i_oe_n,
  input  wire logic [`MWC_DATA_W-1:0] i_dq,
  input  wire logic                   i_dq_oe,
  output logic [`MWC_DATA_W-1:0]      o_dq,
  output int                          o_clash
);
  logic [`MWC_DATA_W-1:0] mem [16];
  logic [`MWC_DATA_W-1:0] pat = 8'h5a;
  logic                   drv;
  // floats whenever the write strobe is low, so no turn-on before it rises
  assign drv  = !i_ce_n && !i_oe_n && i_we_n;
  // floating wire shows a pattern that flips every cycle, not the last value
  assign o_dq = drv ? mem[i_addr[3:0]] : pat;
  initial o_clash = 0;
  // clock only samples the pins; last sample inside the overlap wins
  always @(posedge i_clk) begin
    if (!i_ce_n && !i_we_n) begin
      mem[i_addr[3:0]] <= i_dq;
    end
    if (drv && i_dq_oe) begin
      o_clash <= o_clash + 1;
    end
    pat <= ~pat;
  end
endmodule : mwc_mem_model

// *** tb_mwc_ctrl.sv ***
// self-checking bench for the write-cycle controller
`include "mwc_map.svh"
`define MWC_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_mwc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   req_valid = 1'b0;
  mwc_pkg::mwc_req_t      req = '0;
  logic                   ready, done, ce_n, we_n, oe_n, dq_oe;
  logic [`MWC_ADDR_W-1:0] addr;
  logic [`MWC_DATA_W-1:0] dq, mem_dq, wire_dq;
  int                     n_errors = 0, comparisons = 0, clash;
  always #20 clk = ~clk;
  // host owns the shared wire only while its enable is high
  assign wire_dq = dq_oe ? dq : mem_dq;
  mwc_ctrl mwc_ctrl_inst (.i_clk(clk), .i_resetn(resetn), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(ready), .o_done(done), .o_mem_addr(addr), .o_mem_ce_n(ce_n),
    .o_mem_we_n(we_n), .o_mem_oe_n(oe_n), .o_mem_dq(dq), .o_mem_dq_oe(dq_oe),
    .i_mem_dq(wire_dq));
  mwc_mem_model mwc_mem_model_inst (.i_clk(clk), .i_addr(addr), .i_ce_n(ce_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .i_dq(wire_dq), .i_dq_oe(dq_oe), .o_dq(mem_dq),
    .o_clash(clash));
  task automatic report_and_stop;
    $display("errors %0d of %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // strobes and output drive parked high, wire released
  task automatic check_idle;
    `MWC_CHK({ce_n, we_n, oe_n, dq_oe}, 4'he)
  endtask : check_idle
  // one request; starts and ends just after a falling edge
  task automatic do_write(input logic m, input logic ol, input logic [18:0] a,
                          input logic [7:0] d);
    int n;
    req_valid = 1'b1;
    req = '{mode: mwc_pkg::mwc_mode_t'(m), oe_low: ol, addr: a, data: d};
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    `MWC_CHK(ready, 1'b0)
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `MWC_CHK(n, (ol && !m) ? 5 : 4)
    check_idle;
    `MWC_CHK(mwc_mem_model_inst.mem[a[3:0]], d)
  endtask : do_write
  // all four mode and output-drive pairs back to back, edge addresses
  task automatic t_modes;
    logic [18:0] at [4] = '{19'h0_0000, 19'h7_ffff, 19'h2_aaaa, 19'h5_5555};
    logic [7:0]  dt [4] = '{8'ha5, 8'h5a, 8'hff, 8'h01};
    for (int i = 0; i < 4; i++) begin
      do_write(i[1], i[0], at[i], dt[i]);
    end
  endtask : t_modes
  // same byte rewritten at once; only the second value may remain
  task automatic t_overwrite;
    do_write(1'b0, 1'b0, 19'h1_0006, 8'h3c);
    do_write(1'b1, 1'b1, 19'h1_0006, 8'hc3);
  endtask : t_overwrite
  // reset lands inside the strobe phase
  task automatic t_reset_mid;
    req_valid = 1'b1;
    req = '{mode: mwc_pkg::MWC_WE_CTRL, oe_low: 1'b0, addr: 19'h0_0003, data: 8'h77};
    repeat (2) @(negedge clk);
    req_valid = 1'b0;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check_idle;
    `MWC_CHK(ready, 1'b1)
    resetn = 1'b1;
    @(negedge clk);
    do_write(1'b1, 1'b0, 19'h0_0003, 8'h99);
  endtask : t_reset_mid
  initial begin
    repeat (8) @(negedge clk);
    check_idle;
    resetn = 1'b1;
    @(negedge clk);
    t_modes;
    t_overwrite;
    t_reset_mid;
    `MWC_CHK(clash, 0)
    report_and_stop;
  end
  // tests need well under a hundred cycles
  initial begin
    repeat (400) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
endmodule : tb_mwc_ctrl
